// ===== strap_pkg.sv
package strap_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int STUCK_TIMEOUT_S = 5;
  localparam int STUCK_TIMEOUT_CYCLES = STUCK_TIMEOUT_S * CLK_HZ;
  localparam int SETTLE_CYCLES = 3;
  localparam int DEBOUNCE_CYCLES = 4;
  localparam int PORT_IDLE_CYCLES = 1024;

  // ----------------------------------------
  // Strap field positions
  // ----------------------------------------
  localparam int STRAP_W = 16;
  localparam int BIT_DEBOUNCE = 0;
  localparam int HOST_IF_LSB = 1;
  localparam int DEV_ID_LSB = 4;
  localparam int BIT_EEPROM_SKIP = 7;
  localparam int BIT_HOTSWAP = 9;
  localparam int BIT_POWER_SAVE = 11;
  localparam int BIT_TIMEOUT = 12;

  // ----------------------------------------
  // Shared data and address pin positions
  // ----------------------------------------
  localparam int DATA_W = 16;
  localparam int MII_TXD_LSB = 0;
  localparam int MII_TXCLK_PIN = 4;
  localparam int MII_TXEN_PIN = 5;
  localparam int MII_RXD_LSB = 8;
  localparam int MII_RXCLK_PIN = 12;
  localparam int MII_RXDV_PIN = 13;
  localparam int SDA_PIN = 0;
  localparam int SCL_PIN = 1;

  typedef enum logic [2:0] {
    HOST_PAR16 = 3'h0,
    HOST_PAR8 = 3'h1,
    HOST_SER_MII = 3'h2,
    HOST_SER = 3'h3,
    HOST_UNMANAGED = 3'h7
  } host_if_t;

  typedef struct packed {
    logic timeout_en;
    logic power_save_en;
    logic hotswap_en;
    logic eeprom_skip;
    logic [2:0] dev_id;
    logic [2:0] host_if;
    logic debounce_en;
  } strap_cfg_t;

  typedef struct packed {
    logic [7:0] fast;
    logic uplink_txen;
    logic uplink_txer;
  } module_type_t;

  typedef struct packed {
    logic [15:0] strap;
    logic [7:0] fast_txen;
    logic uplink_txen;
    logic uplink_txer;
    logic [2:0] addr;
    logic we_n;
    logic rd_n;
    logic cs_n;
    logic [15:0] data;
  } pin_in_t;

endpackage

// ===== stuck_timeout_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module stuck_timeout_monitor #(
  parameter int NUM_SM = 4,
  parameter int CYCLES = strap_pkg::STUCK_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic enable,
  input wire logic [NUM_SM-1:0] sm_busy,
  output logic timeout
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] busy_cnt [NUM_SM];
  logic fire;

  // ----------------------------------------
  // Per machine busy counters
  // ----------------------------------------
  always_comb begin
    fire = 1'b0;
    for (int i = 0; i < NUM_SM; i++) begin
      if (enable && sm_busy[i] && busy_cnt[i] == CW'(CYCLES)) begin
        fire = 1'b1;
      end
    end
  end

  // Cleared on fire, so a machine parked busy fires once per count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_SM; i++) begin
        busy_cnt[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NUM_SM; i++) begin
        if (!enable || !sm_busy[i] || fire) begin
          busy_cnt[i] <= '0;
        end else if (busy_cnt[i] != CW'(CYCLES)) begin
          busy_cnt[i] <= busy_cnt[i] + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timeout <= 1'b0;
    end else if (clk_en) begin
      timeout <= fire;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_stuck_gated: assert property (
    @(posedge clk) disable iff (!resetn)
    timeout |-> $past(enable))
    else $error("timeout raised while monitor disabled");

endmodule
`default_nettype wire

// ===== mgmt_strap_decode_pinmux.sv
//
// Contract
// - Capture strap bus and transmit-enable straps at reset, hold as config.
// - Strap bits 3..1 choose one of five host interfaces.
// - Code 000: 16-bit parallel port, three address, strobes, 16 data.
// - Code 001: 8-bit parallel port on data 0-7; 8-15 unused.
// - Code 010: serial plus MII; parallel address pins unused.
// - Serial-MII: tx data 0-3, tx clock 4, tx valid 5, rx 8-13.
// - Code 011: serial only; parallel data pins unused.
// - Only code 111 turns address 0 into SDA, address 1 into SCL.
// - Serial strobe debounced when strap bit 0 high, bypassed when low.
// - Serial device ID from strap bits 6..4; answer only that ID.
// - Unmanaged with strap bit 7 low: request EEPROM load after reset.
// - EEPROM strap ignored outside unmanaged serial mode.
// - Hotswap strap bit 9: report module types from transmit straps.
// - Power saving strap bit 11: idle ports sleep, wake on activity.
// - Strap bit 12: flag machines non-idle for over five seconds.
// - Unmanaged switches right after reset; others wait for init done.
`timescale 1ns/1ps
`default_nettype none
module mgmt_strap_decode_pinmux #(
  parameter int NUM_PORTS = 9,
  parameter int NUM_SM = 4,
  parameter int STUCK_CYCLES = strap_pkg::STUCK_TIMEOUT_CYCLES,
  parameter int IDLE_CYCLES = strap_pkg::PORT_IDLE_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [15:0] bootstrap_strap_bus,
  input wire logic [7:0] fast_port_tx_enable_straps,
  input wire logic uplink_tx_enable_strap,
  input wire logic uplink_tx_error_strap,
  input wire logic [2:0] addr_pin_in,
  output logic [1:0] addr_pin_out,
  output logic [1:0] addr_pin_oe,
  input wire logic we_pin_in,
  input wire logic rd_pin_in,
  output logic rd_pin_out,
  output logic rd_pin_oe,
  input wire logic cs_pin_in,
  input wire logic [15:0] data_pin_in,
  output logic [15:0] data_pin_out,
  output logic [15:0] data_pin_oe,
  output logic host_int_n,
  input wire logic core_irq,
  input wire logic [15:0] core_rdata,
  output logic [2:0] host_addr,
  output logic host_wr,
  output logic host_rd,
  output logic [15:0] host_wdata,
  output logic serial_strobe,
  output logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic [2:0] serial_frame_id,
  input wire logic serial_frame_id_valid,
  output logic serial_id_hit,
  input wire logic [3:0] mgmt_tx_data,
  input wire logic mgmt_tx_valid,
  output logic [3:0] mgmt_rx_data,
  output logic mgmt_port_rx_valid,
  output logic mgmt_port_tx_clock,
  input wire logic i2c_sda_low,
  input wire logic i2c_scl,
  output logic i2c_sda_in,
  output logic eeprom_load_req,
  output strap_pkg::strap_cfg_t cfg,
  output strap_pkg::module_type_t module_type,
  output logic cfg_valid,
  input wire logic init_complete,
  output logic switching_enable,
  input wire logic [NUM_PORTS-1:0] port_activity,
  output logic [NUM_PORTS-1:0] port_power_save,
  input wire logic [NUM_SM-1:0] sm_busy,
  output logic device_reset_req
);

  localparam int DBW = $clog2(strap_pkg::DEBOUNCE_CYCLES + 1);
  localparam int IW = $clog2(IDLE_CYCLES + 1);

  typedef enum logic [2:0] {
    ST_SETTLE = 3'b001,
    ST_CAPTURE = 3'b010,
    ST_RUN = 3'b100
  } state_t;

  function automatic logic is_serial(input logic [2:0] mode);
    return mode != strap_pkg::HOST_PAR16 && mode != strap_pkg::HOST_PAR8;
  endfunction

  function automatic strap_pkg::strap_cfg_t decode(input logic [15:0] s);
    strap_pkg::strap_cfg_t c;
    c.debounce_en = s[strap_pkg::BIT_DEBOUNCE];
    c.host_if = s[strap_pkg::HOST_IF_LSB +: 3];
    c.dev_id = s[strap_pkg::DEV_ID_LSB +: 3];
    c.eeprom_skip = s[strap_pkg::BIT_EEPROM_SKIP];
    c.hotswap_en = s[strap_pkg::BIT_HOTSWAP];
    c.power_save_en = s[strap_pkg::BIT_POWER_SAVE];
    c.timeout_en = s[strap_pkg::BIT_TIMEOUT];
    return c;
  endfunction

  strap_pkg::pin_in_t pin_meta, pin_sync;
  state_t state;
  logic [1:0] settle_cnt;
  logic stuck_timeout, serial_mode, unmanaged, par_rd;
  logic [DBW-1:0] db_cnt;
  logic [IW-1:0] idle_cnt [NUM_PORTS];

  assign serial_mode = is_serial(cfg.host_if);
  assign unmanaged = cfg.host_if == strap_pkg::HOST_UNMANAGED;
  assign par_rd = !pin_sync.rd_n && !pin_sync.cs_n;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (clk_en) begin
      pin_meta <= {bootstrap_strap_bus, fast_port_tx_enable_straps,
                   uplink_tx_enable_strap, uplink_tx_error_strap,
                   addr_pin_in, we_pin_in, rd_pin_in, cs_pin_in,
                   data_pin_in};
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------
  // Strap capture sequence
  // ----------------------------------------
  // Settle lets the synchroniser fill before straps are trusted
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_SETTLE;
      settle_cnt <= '0;
      cfg <= '0;
      module_type <= '0;
      cfg_valid <= 1'b0;
      eeprom_load_req <= 1'b0;
      device_reset_req <= 1'b0;
    end else if (clk_en) begin
      eeprom_load_req <= 1'b0;
      device_reset_req <= stuck_timeout;
      if (stuck_timeout) begin
        state <= ST_SETTLE;
        settle_cnt <= '0;
        cfg_valid <= 1'b0;
      end else begin
        unique case (state)
          ST_SETTLE: begin
            settle_cnt <= settle_cnt + 2'd1;
            if (settle_cnt == 2'(strap_pkg::SETTLE_CYCLES - 1)) begin
              state <= ST_CAPTURE;
            end
          end
          ST_CAPTURE: begin
            cfg <= decode(pin_sync.strap);
            if (pin_sync.strap[strap_pkg::BIT_HOTSWAP]) begin
              module_type <= {pin_sync.fast_txen, pin_sync.uplink_txen,
                              pin_sync.uplink_txer};
            end else begin
              module_type <= '0;
            end
            cfg_valid <= 1'b1;
            state <= ST_RUN;
          end
          ST_RUN: begin
            eeprom_load_req <= !cfg_valid; // unused path kept low
          end
        endcase
        if (state == ST_RUN && cfg_valid && settle_cnt != '0) begin
          settle_cnt <= '0;
          eeprom_load_req <= unmanaged && !cfg.eeprom_skip;
        end
      end
    end
  end

  // ----------------------------------------
  // Switching start
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      switching_enable <= 1'b0;
    end else if (clk_en) begin
      if (stuck_timeout || !cfg_valid) begin
        switching_enable <= 1'b0;
      end else if (unmanaged || init_complete) begin
        switching_enable <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Host interrupt and parallel port
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      host_int_n <= 1'b1;
      host_addr <= '0;
      host_wr <= 1'b0;
      host_rd <= 1'b0;
      host_wdata <= '0;
    end else if (clk_en) begin
      host_int_n <= !core_irq;
      host_addr <= serial_mode ? 3'h0 : pin_sync.addr;
      host_wr <= cfg_valid && !serial_mode && !pin_sync.we_n
                 && !pin_sync.cs_n;
      host_rd <= cfg_valid && !serial_mode && par_rd;
      if (cfg.host_if == strap_pkg::HOST_PAR8) begin
        host_wdata <= {8'h00, pin_sync.data[7:0]};
      end else if (!serial_mode) begin
        host_wdata <= pin_sync.data;
      end
    end
  end

  // ----------------------------------------
  // Shared data pins
  // ----------------------------------------
  // Pin 4 clock is a divide by two of clk; data moves on its low edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_pin_out <= '0;
      data_pin_oe <= '0;
      mgmt_port_tx_clock <= 1'b0;
      mgmt_rx_data <= '0;
      mgmt_port_rx_valid <= 1'b0;
    end else if (clk_en) begin
      data_pin_oe <= '0;
      mgmt_port_tx_clock <= 1'b0;
      mgmt_rx_data <= '0;
      mgmt_port_rx_valid <= 1'b0;
      if (cfg_valid) begin
        unique case (cfg.host_if)
          strap_pkg::HOST_PAR16: begin
            data_pin_out <= core_rdata;
            data_pin_oe <= {16{par_rd}};
          end
          strap_pkg::HOST_PAR8: begin
            data_pin_out <= {8'h00, core_rdata[7:0]};
            data_pin_oe <= {8'h00, {8{par_rd}}};
          end
          strap_pkg::HOST_SER_MII: begin
            mgmt_port_tx_clock <= !mgmt_port_tx_clock;
            if (mgmt_port_tx_clock) begin
              data_pin_out[strap_pkg::MII_TXD_LSB +: 4] <= mgmt_tx_data;
              data_pin_out[strap_pkg::MII_TXEN_PIN] <= mgmt_tx_valid;
            end
            data_pin_out[strap_pkg::MII_TXCLK_PIN] <= !mgmt_port_tx_clock;
            data_pin_out[strap_pkg::MII_RXCLK_PIN] <= !mgmt_port_tx_clock;
            data_pin_oe[strap_pkg::MII_TXD_LSB +: 4] <= 4'hF;
            data_pin_oe[strap_pkg::MII_TXCLK_PIN] <= 1'b1;
            data_pin_oe[strap_pkg::MII_TXEN_PIN] <= 1'b1;
            data_pin_oe[strap_pkg::MII_RXCLK_PIN] <= 1'b1;
            mgmt_rx_data <= pin_sync.data[strap_pkg::MII_RXD_LSB +: 4];
            mgmt_port_rx_valid <= pin_sync.data[strap_pkg::MII_RXDV_PIN];
          end
          default: begin
            data_pin_oe <= '0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Serial pins, device ID, I2C
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_pin_out <= 1'b0;
      rd_pin_oe <= 1'b0;
      serial_data_in <= 1'b0;
      serial_id_hit <= 1'b0;
      addr_pin_out <= '0;
      addr_pin_oe <= '0;
      i2c_sda_in <= 1'b1;
    end else if (clk_en) begin
      rd_pin_out <= serial_data_out;
      rd_pin_oe <= cfg_valid && serial_mode;
      serial_data_in <= serial_mode && !pin_sync.cs_n ? 1'b0
                        : serial_mode && pin_sync.cs_n;
      serial_id_hit <= cfg_valid && serial_mode && serial_frame_id_valid
                       && serial_frame_id == cfg.dev_id;
      addr_pin_out <= {i2c_scl, 1'b0};
      addr_pin_oe[strap_pkg::SDA_PIN] <= cfg_valid && unmanaged
                                         && i2c_sda_low;
      addr_pin_oe[strap_pkg::SCL_PIN] <= cfg_valid && unmanaged;
      i2c_sda_in <= unmanaged ? pin_sync.addr[strap_pkg::SDA_PIN] : 1'b1;
    end
  end

  // ----------------------------------------
  // Strobe debounce
  // ----------------------------------------
  // Costs DEBOUNCE_CYCLES of strobe latency in return for glitch immunity
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial_strobe <= 1'b0;
      db_cnt <= '0;
    end else if (clk_en) begin
      if (!serial_mode || !cfg_valid) begin
        serial_strobe <= 1'b0;
        db_cnt <= '0;
      end else if (!cfg.debounce_en) begin
        serial_strobe <= pin_sync.we_n;
      end else if (pin_sync.we_n == serial_strobe) begin
        db_cnt <= '0;
      end else if (db_cnt == DBW'(strap_pkg::DEBOUNCE_CYCLES - 1)) begin
        serial_strobe <= pin_sync.we_n;
        db_cnt <= '0;
      end else begin
        db_cnt <= db_cnt + DBW'(1);
      end
    end
  end

  // ----------------------------------------
  // Port power saving
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_power_save <= '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        idle_cnt[p] <= '0;
      end
    end else if (clk_en) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (!cfg.power_save_en || port_activity[p]) begin
          idle_cnt[p] <= '0;
          port_power_save[p] <= 1'b0;
        end else if (idle_cnt[p] == IW'(IDLE_CYCLES - 1)) begin
          port_power_save[p] <= 1'b1;
        end else begin
          idle_cnt[p] <= idle_cnt[p] + IW'(1);
        end
      end
    end
  end

  stuck_timeout_monitor #(
    .NUM_SM(NUM_SM),
    .CYCLES(STUCK_CYCLES)
  ) u_monitor (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .enable(cfg_valid && cfg.timeout_en),
    .sm_busy(sm_busy),
    .timeout(stuck_timeout)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_cfg_held: assert property (
    cfg_valid && $past(cfg_valid) |-> $stable(cfg))
    else $error("captured configuration changed");
  a_upper_lane: assert property (
    |data_pin_oe[15:8] |-> cfg.host_if == strap_pkg::HOST_PAR16
    || cfg.host_if == strap_pkg::HOST_SER_MII && data_pin_oe[15:8] == 8'h10)
    else $error("upper data lane driven in wrong mode");
  a_mii_pins: assert property (
    clk_en && cfg_valid && cfg.host_if == strap_pkg::HOST_SER_MII
    |=> data_pin_oe == 16'h103F)
    else $error("management MII pin set wrong");
  a_i2c_only: assert property (
    |addr_pin_oe |-> cfg.host_if == strap_pkg::HOST_UNMANAGED)
    else $error("address pin driven outside unmanaged mode");
  a_irq_follow: assert property (
    clk_en |=> host_int_n == !$past(core_irq))
    else $error("interrupt pin does not follow core");
  a_dout_serial: assert property (
    rd_pin_oe |-> is_serial(cfg.host_if))
    else $error("read pin driven in parallel mode");
  a_id_match: assert property (
    serial_id_hit |-> $past(serial_frame_id) == cfg.dev_id)
    else $error("wrong device ID accepted");
  a_eeprom_mode: assert property (
    eeprom_load_req |-> unmanaged && !cfg.eeprom_skip)
    else $error("EEPROM load requested in wrong mode");
  a_hotswap_off: assert property (
    cfg_valid && !cfg.hotswap_en |-> module_type == '0)
    else $error("module type reported with hotswap off");
  a_sleep_gate: assert property (
    |port_power_save |-> cfg.power_save_en)
    else $error("port sleeping with power saving off");
  a_timeout_rst: assert property (
    clk_en && stuck_timeout |=> !cfg_valid && !switching_enable
    ##0 device_reset_req)
    else $error("timeout did not reset configuration");
  a_switch_gate: assert property (
    $rose(switching_enable) && !unmanaged |-> $past(init_complete))
    else $error("managed mode switched before init");
  a_bypass_db: assert property (
    clk_en && cfg_valid && is_serial(cfg.host_if) && !cfg.debounce_en
    |=> serial_strobe == $past(pin_sync.we_n))
    else $error("strobe not bypassed");

  c_unmanaged_run: cover property (cfg_valid && unmanaged && switching_enable);
  c_mii_mode: cover property (cfg_valid
    && cfg.host_if == strap_pkg::HOST_SER_MII);
  c_timeout: cover property (device_reset_req);
  c_par_read: cover property (data_pin_oe == 16'hFFFF);

endmodule
`default_nettype wire

// ===== fix_note_placeholder.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host side of the shared management pins
// ----------------------------------------
module host_model (
  input wire logic clk,
  input wire logic [15:0] data_pin_out,
  input wire logic [15:0] data_pin_oe,
  input wire logic [1:0] addr_pin_out,
  input wire logic [1:0] addr_pin_oe,
  input wire logic drive,
  input wire logic [15:0] hdata,
  input wire logic [2:0] haddr,
  input wire logic strobe,
  input wire logic sdata,
  output logic [15:0] data_pin_in,
  output logic [2:0] addr_pin_in,
  output logic we_pin_in,
  output logic cs_pin_in
);
  logic [15:0] last;
  // Released lines flip each cycle so stale data never matches
  always_ff @(posedge clk) last <= data_pin_in;
  assign data_pin_in = (data_pin_oe & data_pin_out) |
    (~data_pin_oe & (drive ? hdata : ~last));
  // Bench holds haddr[0] high in unmanaged mode: SDA pull-up
  assign addr_pin_in = {haddr[2],
    addr_pin_oe[1] ? addr_pin_out[1] : haddr[1],
    addr_pin_oe[0] ? addr_pin_out[0] : haddr[0]};
  assign we_pin_in = strobe;
  assign cs_pin_in = sdata;
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----------------------------------------
  // Pins and core side
  // ----------------------------------------
  logic clk = 0, resetn = 0, clk_en = 1, rd_pin_in = 1, core_irq = 0;
  logic [15:0] bootstrap_strap_bus = 0, core_rdata = 0, hdata = 0;
  logic [7:0] fast_port_tx_enable_straps = 0;
  logic uplink_tx_enable_strap = 0, uplink_tx_error_strap = 0;
  logic serial_data_out = 0, serial_frame_id_valid = 0, mgmt_tx_valid = 0;
  logic i2c_sda_low = 0, i2c_scl = 0, init_complete = 0, drive = 1;
  logic strobe = 0, sdata = 1;
  logic [2:0] serial_frame_id = 0, haddr = 0, addr_pin_in, host_addr;
  logic [3:0] mgmt_tx_data = 0, sm_busy = 0, mgmt_rx_data;
  logic [8:0] port_activity = 0, port_power_save;
  logic [1:0] addr_pin_out, addr_pin_oe;
  logic [15:0] data_pin_in, data_pin_out, data_pin_oe, host_wdata;
  logic we_pin_in, cs_pin_in, rd_pin_out, rd_pin_oe, host_int_n, host_wr;
  logic host_rd, serial_strobe, serial_data_in, serial_id_hit;
  logic mgmt_port_rx_valid, mgmt_port_tx_clock, i2c_sda_in;
  logic eeprom_load_req, cfg_valid, switching_enable, device_reset_req;
  strap_pkg::strap_cfg_t cfg;
  strap_pkg::module_type_t module_type;
  int n_mismatch = 0, comparisons = 0, n_eep = 0, n_rst = 0;

  // Short counts keep the stuck and idle checks within a short run
  mgmt_strap_decode_pinmux #(.STUCK_CYCLES(50), .IDLE_CYCLES(8))
    mgmt_strap_decode_pinmux_inst (.*);
  host_model host_model_inst (.*);

  initial forever #12.5 clk = ~clk;

  always @(posedge clk) begin
    if (eeprom_load_req === 1'b1) n_eep++;
    if (device_reset_req === 1'b1) n_rst++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic boot(logic [15:0] s);
    bootstrap_strap_bus = s;
    resetn = 0;
    cyc(8);
    chk("reset_out", {host_int_n, i2c_sda_in, cfg_valid}, 3'b110);
    resetn = 1;
    n_eep = 0;
    cyc(4);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int modes[6] = '{0, 1, 2, 3, 7, 7};
    logic [15:0] s;
    logic [9:0] mt;
    int m, tg;
    logic t;
    void'($urandom(78712));
    sm_busy = 4'hF;
    foreach (modes[i]) begin
      m = modes[i];
      s = 16'($urandom);
      s[3:1] = m[2:0];
      s[7] = i[0];
      s[12] = 0;
      {fast_port_tx_enable_straps, uplink_tx_enable_strap,
        uplink_tx_error_strap, core_irq, serial_data_out, i2c_sda_low,
        haddr, hdata} = $urandom;
      {i2c_scl, mgmt_tx_valid, mgmt_tx_data, core_rdata} = 22'($urandom);
      mt = {fast_port_tx_enable_straps, uplink_tx_enable_strap,
        uplink_tx_error_strap};
      if (m == 7) haddr[0] = 1;
      {init_complete, strobe, sdata, drive, rd_pin_in} = 5'b00011;
      port_activity = 0;
      boot(s);
      chk("cfg_valid", cfg_valid, 1);
      chk("cfg", cfg, {s[12:11], s[9], s[7:0]});
      chk("module_type", module_type, s[9] ? mt : 10'h0);
      cyc(1);
      chk("switch_early", switching_enable, m == 7);
      init_complete = 1;
      bootstrap_strap_bus = ~s;
      cyc(2);
      chk("switch_init", switching_enable, 1);
      strobe = 1;
      cyc(3);
      chk("strobe_fast", serial_strobe, m > 1 && !s[0]);
      cyc(5);
      chk("strobe", serial_strobe, m > 1);
      {drive, rd_pin_in, sdata, strobe} = 4'h0;
      cyc(3);
      chk("host_rd", host_rd, m < 2);
      chk("host_wr", host_wr, m < 2);
      chk("host_addr", host_addr, m < 2 ? haddr : 3'h0);
      chk("data_oe", data_pin_oe, m == 2 ? 16'h103F :
        m == 0 ? 16'hFFFF : m == 1 ? 16'h00FF : 16'h0);
      if (m < 2) chk("data_out", data_pin_out,
        m ? {8'h00, core_rdata[7:0]} : core_rdata);
      {drive, rd_pin_in, sdata} = 3'b111;
      cyc(3);
      chk("serial_in", serial_data_in, m > 1);
      chk("rd_oe", rd_pin_oe, m > 1);
      if (m > 1) chk("rd_out", rd_pin_out, serial_data_out);
      chk("mii_rx", {mgmt_port_rx_valid, mgmt_rx_data},
        m == 2 ? {hdata[13], hdata[11:8]} : 5'h0);
      tg = 0;
      repeat (8) begin
        t = mgmt_port_tx_clock;
        cyc(1);
        tg += (t !== mgmt_port_tx_clock);
      end
      chk("tx_clock", tg, m == 2 ? 8 : 0);
      if (m == 2) begin
        chk("mii_tx", {data_pin_out[5], data_pin_out[3:0]},
          {mgmt_tx_valid, mgmt_tx_data});
      end
      if (m < 2) chk("wdata", host_wdata,
        m ? {8'h00, hdata[7:0]} : hdata);
      chk("addr_oe", addr_pin_oe,
        m == 7 ? {1'b1, i2c_sda_low} : 2'b00);
      chk("addr_out", addr_pin_out, {i2c_scl, 1'b0});
      chk("sda_in", i2c_sda_in, m != 7 || !i2c_sda_low);
      chk("host_int_n", host_int_n, !core_irq);
      // Clock enable low must freeze the toggle and the interrupt pin
      t = mgmt_port_tx_clock;
      clk_en = 0;
      core_irq = !core_irq;
      cyc(3);
      chk("frozen", {mgmt_port_tx_clock, host_int_n},
        {t, core_irq});
      clk_en = 1;
      chk("power_save", port_power_save, s[11] ? 9'h1FF : 9'h0);
      port_activity = 9'h1FF;
      cyc(2);
      chk("power_wake", port_power_save, 0);
      for (int k = 0; k < 2; k++) begin
        serial_frame_id = s[6:4] ^ k[2:0];
        serial_frame_id_valid = 1;
        cyc(1);
        serial_frame_id_valid = 0;
        chk("id_hit", serial_id_hit, m > 1 && k == 0);
        cyc(1);
      end
      chk("cfg_hold", cfg, {s[12:11], s[9], s[7:0]});
      chk("eeprom_req", n_eep, m == 7 && !s[7]);
    end
    chk("no_timeout", n_rst, 0);
    s[12] = 1;
    sm_busy = 0;
    boot(s);
    n_rst = 0;
    sm_busy = 4'h2;
    for (tg = 0; tg < 80 && device_reset_req !== 1'b1; tg++) cyc(1);
    chk("timeout_at", tg >= 50 && tg < 80, 1);
    cyc(1);
    chk("recapture", {cfg_valid, switching_enable}, 2'b00);
    cyc(8);
    chk("reset_pulse", n_rst, 1);
    chk("cfg_again", cfg_valid, 1);
    summarize();
  end

  // Generous bound: the whole sequence needs well under 1000 cycles
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
